/* File: dv/sgc_chain.sv */
`timescale 1ns/100ps
module sgc_chain (
  input wire logic sclk_in,
  input wire logic ld_in,
  input wire logic sdo_in,
  input wire logic [7:0] len_in,
  input wire logic [127:0] pins_in,
  output logic sdi_out,
  output logic [127:0] q_out
);
  logic [127:0] out_sh = '0;
  logic [127:0] in_sh = '0;
  int k = 0;
  // Load strobe and shift clock never rise together
  always @(posedge sclk_in or posedge ld_in) begin
    if (ld_in) begin
      q_out <= out_sh;
      in_sh <= pins_in;
      k <= 0;
    end else begin
      out_sh[k] <= sdo_in;
      k <= k + 1;
    end
  end
  // Past the last stage the line shows the inverse
  assign sdi_out = (k < len_in) ? in_sh[k] : ~in_sh[len_in - 8'h01];
endmodule

/* File: dv/sgc_monitor.sv */
`timescale 1ns/100ps
module sgc_monitor #(
  parameter int MS_CYCLES = 20
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic AXI_AWVALID_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic AXI_WREADY_OUT,
  input wire logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic SERIAL_DATA_OUT,
  input wire logic LOAD_STROBE_OUT
);
  logic [8:0] rise_cnt_ff;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // Serial clock rises since last load
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || LOAD_STROBE_OUT) begin
      rise_cnt_ff <= 9'h000;
    end else if ($rose(SERIAL_CLOCK_OUT)) begin
      rise_cnt_ff <= rise_cnt_ff + 9'h001;
    end
  end
  property p_idle;
    $fell(RST_IN) |-> (!SERIAL_CLOCK_OUT && !LOAD_STROBE_OUT) [*3];
  endproperty
  property p_ld_pulse;
    $rose(LOAD_STROBE_OUT) |=> !LOAD_STROBE_OUT;
  endproperty
  property p_ld_sclk;
    LOAD_STROBE_OUT |-> !SERIAL_CLOCK_OUT;
  endproperty
  property p_sdo_hold;
    SERIAL_CLOCK_OUT |-> $stable(SERIAL_DATA_OUT);
  endproperty
  property p_burst_len;
    rise_cnt_ff <= 9'h080;
  endproperty
  property p_b_hold;
    AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT);
  endproperty
  property p_r_hold;
    AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT);
  endproperty
  property p_b_ans;
    AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT |=> ##1 AXI_BVALID_OUT;
  endproperty
  property p_r_ans;
    AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("activity after reset");
  a_ld_pulse: assert property (p_ld_pulse) else $error("load too long");
  a_ld_sclk: assert property (p_ld_sclk) else $error("load with clock high");
  a_sdo_hold: assert property (p_sdo_hold) else $error("data moved");
  a_burst_len: assert property (p_burst_len) else $error("burst too long");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  c_ld: cover property ($rose(LOAD_STROBE_OUT));
  c_err: cover property (AXI_BVALID_OUT && AXI_BRESP_OUT == 2'h2);
  c_long: cover property (rise_cnt_ff == 9'h00C);
endmodule

bind sgc_top sgc_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (.*);

/* File: dv/tb_sgc_top.sv */
`timescale 1ns/100ps
module tb_sgc_top;
  logic MCLK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic [7:0] AXI_AWADDR_IN = '0, AXI_ARADDR_IN = '0;
  logic [31:0] AXI_WDATA_IN = '0;
  logic [3:0] AXI_WSTRB_IN = 4'hF;
  logic AXI_AWVALID_IN = 1'b0, AXI_WVALID_IN = 1'b0, AXI_BREADY_IN = 1'b0;
  logic AXI_ARVALID_IN = 1'b0, AXI_RREADY_IN = 1'b0;
  logic [15:0] PARALLEL_DETECT_IN = '0;
  logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT;
  logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT;
  logic [31:0] AXI_RDATA_OUT, LOS_OUT, last, cfg;
  logic SERIAL_CLOCK_OUT, SERIAL_DATA_OUT, SERIAL_DATA_IN, LOAD_STROBE_OUT, rv;
  logic [127:0] pins = '0, opins, ein, msk, chq;
  logic [7:0] len = '0;
  logic [65:0] q[$];
  int n_mismatch = 0, checks_done = 0, cyc = 0, nld = 0, n0, s, p;

  sgc_top #(.MS_CYCLES(20)) i_dut (.*);
  sgc_chain i_chain (.sclk_in(SERIAL_CLOCK_OUT), .ld_in(LOAD_STROBE_OUT),
    .sdo_in(SERIAL_DATA_OUT), .len_in(len), .pins_in(pins), .sdi_out(SERIAL_DATA_IN),
    .q_out(chq));

  always #25 MCLK_IN = ~MCLK_IN;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge MCLK_IN);
    AXI_AWADDR_IN <= a;
    AXI_WDATA_IN <= d;
    AXI_AWVALID_IN <= 1'b1;
    AXI_WVALID_IN <= 1'b1;
    AXI_BREADY_IN <= 1'b1;
    do begin
      @(posedge MCLK_IN);
      if (AXI_AWREADY_OUT) AXI_AWVALID_IN <= 1'b0;
      if (AXI_WREADY_OUT) AXI_WVALID_IN <= 1'b0;
      if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
        AXI_BREADY_IN <= 1'b0;
        chk(AXI_BRESP_OUT, er);
      end
    end while (AXI_AWVALID_IN || AXI_WVALID_IN || AXI_BREADY_IN);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    @(posedge MCLK_IN);
    q.push_back({e, m, er});
    AXI_ARADDR_IN <= a;
    AXI_ARVALID_IN <= 1'b1;
    AXI_RREADY_IN <= 1'b1;
    do begin
      @(posedge MCLK_IN);
      if (AXI_ARREADY_OUT) AXI_ARVALID_IN <= 1'b0;
      if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
        AXI_RREADY_IN <= 1'b0;
        last = AXI_RDATA_OUT;
      end
    end while (AXI_ARVALID_IN || AXI_RREADY_IN);
  endtask

  // ----------------------------------------
  // Read watcher and timeout
  // ----------------------------------------
  always @(posedge MCLK_IN) begin
    cyc++;
    if (LOAD_STROBE_OUT) nld++;
    if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
      chk(AXI_RDATA_OUT & q[0][33:2], q[0][65:34] & q[0][33:2]);
      chk(AXI_RRESP_OUT, q[0][1:0]);
      void'(q.pop_front());
    end
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(30863));
    repeat (16) @(posedge MCLK_IN);
    RST_IN <= 1'b0;
    rd(8'h00, 32'h0000001C, '1, 2'h0);
    rd(8'h04, 32'h00000004, '1, 2'h0);
    rd(8'h40, '0, '1, 2'h2);
    wr(8'h20, '1, 2'h2);
    wr(8'h04, 32'h00000002, 2'h0);
    wr(8'h08, 32'h0000000B, 2'h0);
    for (int w = 1; w <= 4; w++) begin
      rv = w[0];
      cfg = 32'h00000011 | (32'(w - 1) << 2) | (rv ? 32'h00000060 : 32'h00000000);
      opins = {$urandom, $urandom, $urandom, $urandom};
      pins <= {$urandom, $urandom, $urandom, $urandom};
      len <= 8'(3 * w);
      for (int k = 0; k < 4; k++) wr(8'h10 + 8'(4 * k), opins[32*k +: 32], 2'h0);
      repeat (2) begin
        wr(8'h00, cfg, 2'h0);
        do rd(8'h00, '0, '0, 2'h0); while (last[31]);
      end
      rd(8'h00, cfg ^ 32'h00000001, '1, 2'h0);
      ein = '0;
      msk = '0;
      s = 0;
      for (int i = 0; i < 32; i++) begin
        p = rv ? 31 - i : i;
        if (p == 0 || p == 1 || p == 3) begin
          for (int b = 0; b < w; b++) begin
            ein[p*4+b] = pins[s];
            msk[p*4+b] = 1'b1;
            chk(chq[s], opins[p*4+b]);
            s++;
          end
        end
      end
      for (int k = 0; k < 4; k++) rd(8'h20 + 8'(4 * k), ein[32*k +: 32], msk[32*k +: 32], 2'h0);
      chk(LOS_OUT[0], ein[0]);
    end
    len <= 8'h03;
    wr(8'h00, 32'h00000212, 2'h0);
    n0 = nld;
    repeat (300) @(posedge MCLK_IN);
    chk(nld - n0 >= 4 && nld - n0 <= 5, 1);
    wr(8'h00, 32'h00000292, 2'h0);
    n0 = nld;
    repeat (200) @(posedge MCLK_IN);
    chk(nld - n0 >= 9 && nld - n0 <= 11, 1);
    wr(8'h00, 32'h00000010, 2'h0);
    repeat (100) @(posedge MCLK_IN);
    n0 = nld;
    repeat (200) @(posedge MCLK_IN);
    chk(nld, n0);
    wr(8'h34, 32'h00000300, 2'h0);
    wr(8'h0C, 32'h00000020, 2'h0);
    for (int v = 0; v < 2; v++) begin
      PARALLEL_DETECT_IN <= {10'($urandom), v[0], 5'($urandom)};
      repeat (4) @(posedge MCLK_IN);
      chk(LOS_OUT[3], v);
      chk(LOS_OUT[1], pins[1]);
    end
    close_out();
  end
endmodule

/* File: pkg/sgc_pkg.sv */
package sgc_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int PORTS = 32;
  localparam int PORT_BITS = 4;
  localparam int PINS = PORTS * PORT_BITS;
  localparam int DETECTS = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOAD_MIN_NS = 25;
  localparam int LOAD_MAX_NS = 30;
  localparam int LOAD_CYC_RAW = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CYC = (LOAD_CYC_RAW < 1) ? 1 : LOAD_CYC_RAW;
  localparam int GAP_STEP_MS = 1;
  localparam logic [5:0] GAP_MAX_MS = 6'h21;
  localparam int MS_CYCLES = GAP_STEP_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CLOCK = 8'h04;
  localparam logic [7:0] ADDR_PORT_ENA = 8'h08;
  localparam logic [7:0] ADDR_DET_ENA = 8'h0C;
  localparam logic [3:0] PAGE_OUT = 4'h1;
  localparam logic [3:0] PAGE_IN = 4'h2;
  localparam logic [3:0] PAGE_DMAP = 4'h3;
  localparam int CFG_BUSY = 31;
  localparam int DMAP_FIELD = 8;

  localparam logic [1:0] RST_WIDTH = 2'h3;
  localparam logic RST_LD_POL = 1'b1;
  localparam logic [5:0] RST_GAP = 6'h00;
  localparam logic [7:0] RST_RATE = 8'h04;
  localparam logic [31:0] RST_PORT_ENA = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Bit layout equals the configuration word, bits 13:0
  typedef struct packed {
    logic [5:0] burst_gap_length;
    logic burst_gap_disable;
    logic reverse_out_order;
    logic reverse_in_order;
    logic load_strobe_polarity;
    logic [1:0] bits_per_port;
    logic repeat_bursts;
    logic single_burst_request;
  } sgc_cfg_s;

  localparam sgc_cfg_s RST_CFG = '{
    burst_gap_length: RST_GAP, burst_gap_disable: 1'b0, reverse_out_order: 1'b0,
    reverse_in_order: 1'b0, load_strobe_polarity: RST_LD_POL, bits_per_port: RST_WIDTH,
    repeat_bursts: 1'b0, single_burst_request: 1'b0};

  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_LOAD, ST_GAP} sgc_state_e;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Nearest enabled port at or beyond st; bit 5 flags found
  function automatic logic [5:0] sgc_next_port(input logic [31:0] m, input int st,
                                               input logic rev);
    logic [5:0] r;
    r = 6'h00;
    if (!rev) begin
      for (int j = PORTS - 1; j >= 0; j--) begin
        if (m[j] && j >= st) begin
          r = {1'b1, 5'(j)};
        end
      end
    end else begin
      for (int j = 0; j < PORTS; j++) begin
        if (m[j] && j <= st) begin
          r = {1'b1, 5'(j)};
        end
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] sgc_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: rtl/sgc_clkdiv.sv */
`timescale 1ns/100ps
module sgc_clkdiv #(
  parameter int MS_CYCLES = 20000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [7:0] rate_in,
  input wire logic ms_clr_in,
  output logic shift_tick_out,
  output logic ms_tick_out
);

  // ---------------------------------------------------------------
  // Half-period enable for the serial clock
  // ---------------------------------------------------------------
  logic [7:0] div_ff;
  logic [31:0] ms_ff;

  assign shift_tick_out = run_in && (div_ff == rate_in);

  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in || shift_tick_out) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Millisecond enable for the burst gap
  // ---------------------------------------------------------------
  assign ms_tick_out = (ms_ff == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || ms_clr_in || ms_tick_out) begin
      ms_ff <= 32'h00000000;
    end else begin
      ms_ff <= ms_ff + 32'h00000001;
    end
  end

endmodule

/* File: rtl/sgc_top.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module sgc_top #(
  parameter int MS_CYCLES = sgc_pkg::MS_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [7:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_IN,
  output logic LOAD_STROBE_OUT,
  input wire logic [15:0] PARALLEL_DETECT_IN,
  output logic [31:0] LOS_OUT
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  sgc_pkg::sgc_cfg_s cfg_ff;
  logic [7:0] rate_ff;
  logic [31:0] port_enable_mask_ff;
  logic [15:0] det_ena_ff;
  logic [15:0][4:0] detect_port_map_ff;
  logic [sgc_pkg::PINS-1:0] out_data_ff;
  logic [sgc_pkg::PINS-1:0] sampled_inputs_ff;

  sgc_pkg::sgc_state_e state_ff;
  sgc_pkg::sgc_state_e nxt_state;
  logic [31:0] mask_l_ff;
  logic [1:0] width_l_ff;
  logic rev_in_l_ff;
  logic rev_out_l_ff;
  logic [4:0] out_port_ff;
  logic [4:0] in_port_ff;
  logic [1:0] bit_ff;
  logic [5:0] gap_cnt_ff;
  logic [1:0] ld_cnt_ff;
  logic shift_tick;
  logic ms_tick;
  logic burst_done;
  logic last_slot;
  logic [5:0] out_first;
  logic [5:0] in_first;
  logic [5:0] out_nxt;
  logic [5:0] in_nxt;
  logic [5:0] gap_target;

  logic di_meta_ff;
  logic di_sync_ff;
  logic [15:0] pd_meta_ff;
  logic [15:0] pd_sync_ff;
  logic sclk_ff;
  logic sdo_ff;
  logic ld_ff;
  logic [31:0] los_ff;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  assign AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
  assign AXI_WREADY_OUT = !w_held_ff && !bvalid_ff;
  assign AXI_BVALID_OUT = bvalid_ff;
  assign AXI_BRESP_OUT = bresp_ff;
  assign AXI_ARREADY_OUT = !rvalid_ff;
  assign AXI_RVALID_OUT = rvalid_ff;
  assign AXI_RRESP_OUT = rresp_ff;
  assign AXI_RDATA_OUT = rdata_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = (waddr_ff[7:4] <= sgc_pkg::PAGE_DMAP) && (waddr_ff[1:0] == 2'h0) &&
                  (waddr_ff[7:4] != sgc_pkg::PAGE_IN);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= sgc_pkg::RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_held_ff <= 1'b1;
        waddr_ff <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_held_ff <= 1'b1;
        wdata_ff <= AXI_WDATA_IN;
        wstrb_ff <= AXI_WSTRB_IN;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? sgc_pkg::RESP_OKAY : sgc_pkg::RESP_SLVERR;
      end else if (bvalid_ff && AXI_BREADY_IN) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = (AXI_ARADDR_IN[1:0] == 2'h0);
    unique case (AXI_ARADDR_IN[7:4])
      4'h0: begin
        unique case (AXI_ARADDR_IN[3:2])
          2'h0: begin
            rd_word[13:0] = cfg_ff;
            rd_word[sgc_pkg::CFG_BUSY] = (state_ff != sgc_pkg::ST_IDLE);
          end
          2'h1: rd_word[7:0] = rate_ff;
          2'h2: rd_word = port_enable_mask_ff;
          2'h3: rd_word[15:0] = det_ena_ff;
        endcase
      end
      sgc_pkg::PAGE_OUT: rd_word = out_data_ff[32*AXI_ARADDR_IN[3:2] +: 32];
      sgc_pkg::PAGE_IN: rd_word = sampled_inputs_ff[32*AXI_ARADDR_IN[3:2] +: 32];
      sgc_pkg::PAGE_DMAP: begin
        for (int j = 0; j < 4; j++) begin
          rd_word[sgc_pkg::DMAP_FIELD*j +: 5] = detect_port_map_ff[4*AXI_ARADDR_IN[3:2] + j];
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= sgc_pkg::RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? sgc_pkg::RESP_OKAY : sgc_pkg::RESP_SLVERR;
      rdata_ff <= rd_hit ? rd_word : 32'h00000000;
    end else if (rvalid_ff && AXI_RREADY_IN) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  logic [31:0] cfg_merged;
  logic [31:0] det_merged;

  assign cfg_merged = sgc_pkg::sgc_merge({18'h00000, cfg_ff}, wdata_ff, wstrb_ff);
  assign det_merged = sgc_pkg::sgc_merge({16'h0000, det_ena_ff}, wdata_ff, wstrb_ff);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cfg_ff <= sgc_pkg::RST_CFG;
    end else if (wr_fire && waddr_ff == sgc_pkg::ADDR_CFG) begin
      cfg_ff <= sgc_pkg::sgc_cfg_s'(cfg_merged[13:0]);
    end else if (burst_done) begin
      cfg_ff.single_burst_request <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rate_ff <= sgc_pkg::RST_RATE;
      port_enable_mask_ff <= sgc_pkg::RST_PORT_ENA;
      det_ena_ff <= 16'h0000;
      detect_port_map_ff <= '0;
      out_data_ff <= '0;
    end else if (wr_fire && wr_hit) begin
      if (waddr_ff == sgc_pkg::ADDR_CLOCK && wstrb_ff[0]) begin
        rate_ff <= wdata_ff[7:0];
      end
      if (waddr_ff == sgc_pkg::ADDR_PORT_ENA) begin
        port_enable_mask_ff <= sgc_pkg::sgc_merge(port_enable_mask_ff, wdata_ff, wstrb_ff);
      end
      if (waddr_ff == sgc_pkg::ADDR_DET_ENA) begin
        det_ena_ff <= det_merged[15:0];
      end
      if (waddr_ff[7:4] == sgc_pkg::PAGE_OUT) begin
        out_data_ff[32*waddr_ff[3:2] +: 32] <=
          sgc_pkg::sgc_merge(out_data_ff[32*waddr_ff[3:2] +: 32], wdata_ff, wstrb_ff);
      end
      if (waddr_ff[7:4] == sgc_pkg::PAGE_DMAP) begin
        for (int j = 0; j < 4; j++) begin
          if (wstrb_ff[j]) begin
            detect_port_map_ff[4*waddr_ff[3:2] + j] <= wdata_ff[sgc_pkg::DMAP_FIELD*j +: 5];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      di_meta_ff <= 1'b0;
      di_sync_ff <= 1'b0;
      pd_meta_ff <= 16'h0000;
      pd_sync_ff <= 16'h0000;
    end else begin
      di_meta_ff <= SERIAL_DATA_IN;
      di_sync_ff <= di_meta_ff;
      pd_meta_ff <= PARALLEL_DETECT_IN;
      pd_sync_ff <= pd_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Burst sequencer
  // ---------------------------------------------------------------
  sgc_clkdiv #(
    .MS_CYCLES(MS_CYCLES)
  ) u_div (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .run_in(state_ff == sgc_pkg::ST_LOW || state_ff == sgc_pkg::ST_HIGH),
    .rate_in(rate_ff),
    .ms_clr_in(state_ff != sgc_pkg::ST_GAP),
    .shift_tick_out(shift_tick),
    .ms_tick_out(ms_tick)
  );

  // Enabled ports only, each direction on its own order
  assign out_first = sgc_pkg::sgc_next_port(port_enable_mask_ff,
                       cfg_ff.reverse_out_order ? 31 : 0, cfg_ff.reverse_out_order);
  assign in_first = sgc_pkg::sgc_next_port(port_enable_mask_ff,
                       cfg_ff.reverse_in_order ? 31 : 0, cfg_ff.reverse_in_order);
  assign out_nxt = sgc_pkg::sgc_next_port(mask_l_ff,
                     rev_out_l_ff ? int'(out_port_ff) - 1 : int'(out_port_ff) + 1, rev_out_l_ff);
  assign in_nxt = sgc_pkg::sgc_next_port(mask_l_ff,
                    rev_in_l_ff ? int'(in_port_ff) - 1 : int'(in_port_ff) + 1, rev_in_l_ff);
  // At most 32 ports of 4 bits per burst
  assign last_slot = (bit_ff == width_l_ff) && !out_nxt[5];
  assign burst_done = (state_ff == sgc_pkg::ST_LOAD) &&
                      (ld_cnt_ff == 2'(sgc_pkg::LOAD_CYC - 1));
  assign gap_target = (cfg_ff.burst_gap_length > sgc_pkg::GAP_MAX_MS) ?
                      sgc_pkg::GAP_MAX_MS : cfg_ff.burst_gap_length;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sgc_pkg::ST_IDLE: begin
        if (cfg_ff.single_burst_request || cfg_ff.repeat_bursts) begin
          nxt_state = out_first[5] ? sgc_pkg::ST_LOW : sgc_pkg::ST_LOAD;
        end
      end
      sgc_pkg::ST_LOW: begin
        if (shift_tick) begin
          nxt_state = sgc_pkg::ST_HIGH;
        end
      end
      sgc_pkg::ST_HIGH: begin
        if (shift_tick) begin
          nxt_state = last_slot ? sgc_pkg::ST_LOAD : sgc_pkg::ST_LOW;
        end
      end
      sgc_pkg::ST_LOAD: begin
        if (burst_done) begin
          if (cfg_ff.repeat_bursts && !cfg_ff.burst_gap_disable && gap_target != 6'h00) begin
            nxt_state = sgc_pkg::ST_GAP;
          end else begin
            nxt_state = sgc_pkg::ST_IDLE;
          end
        end
      end
      sgc_pkg::ST_GAP: begin
        if (!cfg_ff.repeat_bursts || cfg_ff.burst_gap_disable || gap_cnt_ff >= gap_target) begin
          nxt_state = sgc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_ff <= sgc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Slot pointers, settings latched per burst
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      mask_l_ff <= 32'h00000000;
      width_l_ff <= 2'h0;
      rev_in_l_ff <= 1'b0;
      rev_out_l_ff <= 1'b0;
      out_port_ff <= 5'h00;
      in_port_ff <= 5'h00;
      bit_ff <= 2'h0;
    end else if (state_ff == sgc_pkg::ST_IDLE) begin
      mask_l_ff <= port_enable_mask_ff;
      width_l_ff <= cfg_ff.bits_per_port;
      rev_in_l_ff <= cfg_ff.reverse_in_order;
      rev_out_l_ff <= cfg_ff.reverse_out_order;
      out_port_ff <= out_first[4:0];
      in_port_ff <= in_first[4:0];
      bit_ff <= 2'h0;
    end else if (state_ff == sgc_pkg::ST_HIGH && shift_tick) begin
      if (bit_ff == width_l_ff) begin
        bit_ff <= 2'h0;
        out_port_ff <= out_nxt[4:0];
        in_port_ff <= in_nxt[4:0];
      end else begin
        bit_ff <= bit_ff + 2'h1;
      end
    end
  end

  // Sample just before the rising serial clock
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      sampled_inputs_ff <= '0;
    end else if (state_ff == sgc_pkg::ST_LOW && shift_tick) begin
      sampled_inputs_ff[{in_port_ff, bit_ff}] <= di_sync_ff;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || state_ff != sgc_pkg::ST_LOAD) begin
      ld_cnt_ff <= 2'h0;
    end else begin
      ld_cnt_ff <= ld_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || state_ff != sgc_pkg::ST_GAP) begin
      gap_cnt_ff <= 6'h00;
    end else if (ms_tick) begin
      gap_cnt_ff <= gap_cnt_ff + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      sclk_ff <= 1'b0;
      sdo_ff <= 1'b0;
      ld_ff <= !sgc_pkg::RST_LD_POL;
    end else begin
      sclk_ff <= (state_ff == sgc_pkg::ST_HIGH);
      sdo_ff <= (state_ff == sgc_pkg::ST_LOW || state_ff == sgc_pkg::ST_HIGH) ?
                out_data_ff[{out_port_ff, bit_ff}] : 1'b0;
      ld_ff <= (state_ff == sgc_pkg::ST_LOAD) ? cfg_ff.load_strobe_polarity :
               !cfg_ff.load_strobe_polarity;
    end
  end

  assign SERIAL_CLOCK_OUT = sclk_ff;
  assign SERIAL_DATA_OUT = sdo_ff;
  assign LOAD_STROBE_OUT = ld_ff;

  // ---------------------------------------------------------------
  // Loss-of-signal forwarding
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      los_ff <= 32'h00000000;
    end else begin
      for (int p = 0; p < sgc_pkg::PORTS; p++) begin
        los_ff[p] <= sampled_inputs_ff[p*sgc_pkg::PORT_BITS];
        for (int n = 0; n < sgc_pkg::DETECTS; n++) begin
          if (det_ena_ff[n] && detect_port_map_ff[n] == 5'(p)) begin
            los_ff[p] <= pd_sync_ff[n];
          end
        end
      end
    end
  end

  assign LOS_OUT = los_ff;

endmodule
